// >>> bench/slc_lin_node.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Remote LIN node: bit ticks and low stretches on the receive line
// ----------------------------------------------------------------
module slc_lin_node (
    input wire i_mclk,
    input wire i_go,
    input wire [3:0] i_low_bits,
    output reg o_line,
    output reg o_tick
);
    reg [1:0] div;
    reg [3:0] left;
    initial begin
        div = 2'h0;
        left = 4'h0;
        o_line = 1'b1;
        o_tick = 1'b0;
    end
    // Tick every fourth clock; line idles high and drops for a stretch
    // of whole bit times, so the low length is exact in ticks
    always @(posedge i_mclk) begin
        div <= div + 2'h1;
        o_tick <= (div == 2'h3);
        if (i_go) begin
            left <= i_low_bits;
            o_line <= 1'b0;
        end else if (o_tick && left != 4'h0) begin
            left <= left - 4'h1;
            o_line <= (left == 4'h1);
        end
    end
endmodule // slc_lin_node

// >>> bench/slc_status_ctrl_monitor.sv
`timescale 1ns/100ps
module slc_status_ctrl_monitor (
    input wire i_mclk,
    input wire i_rst_b,
    input wire [1:0] i_addr,
    input wire [7:0] i_wr_data,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rd_data,
    input wire i_loop_select,
    input wire i_receiver_source_select,
    input wire i_rx_pin,
    input wire i_char_done,
    input wire i_overrun_flag,
    input wire i_parity_error_flag,
    input wire i_tx_level,
    input wire i_send_break,
    input wire o_rx_level,
    input wire o_rx_buffer_full,
    input wire o_framing_error_flag,
    input wire o_noise_flag,
    input wire o_tx_break_active,
    input wire o_tx_pin,
    input wire o_tx_pin_oe,
    input wire o_error_irq
);
    reg [7:0] st;
    reg [7:0] ct;
    // ----------------------------------------------------------------
    // Shadow copies of the control bits, tracked from the write port
    // ----------------------------------------------------------------
    always @(posedge i_mclk) begin
        if (!i_rst_b) begin
            st <= 8'h00;
            ct <= 8'h00;
        end else if (i_wr && i_addr == 2'h0) begin
            st <= i_wr_data;
        end else if (i_wr && i_addr == 2'h1) begin
            ct <= i_wr_data;
        end
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    sequence brk_req;
        i_send_break;
    endsequence
    sequence char_in;
        !st[1] && i_char_done && !o_rx_buffer_full;
    endsequence
    pin_level_a: assert property (o_tx_pin ==
        ((o_tx_break_active ? 1'b0 : i_tx_level) ^ ct[4]))
        else $error("tx pin level wrong");
    pin_dir_a: assert property (o_tx_pin_oe ==
        !(i_loop_select && i_receiver_source_select && !ct[5]))
        else $error("tx pin direction wrong");
    rx_level_a: assert property (o_rx_level == (i_rx_pin ^ st[4]))
        else $error("rx level not inverted as set");
    err_irq_a: assert property (o_error_irq ==
        ((i_overrun_flag & ct[3]) | (o_noise_flag & ct[2]) |
        (o_framing_error_flag & ct[1]) | (i_parity_error_flag & ct[0])))
        else $error("error request wrong");
    rd_zero_a: assert property (!$past(i_rd) || $past(i_addr) > 2'h1
        |-> o_rd_data == 8'h00) else $error("idle read data not zero");
    ctrl_read_a: assert property (i_rd && i_addr == 2'h1
        |=> o_rd_data[6:0] == ct[6:0]) else $error("control readback wrong");
    brk_start_a: assert property (brk_req |=> o_tx_break_active)
        else $error("break did not start");
    full_block_a: assert property (st[1] |=> !$rose(o_rx_buffer_full) &&
        !$rose(o_framing_error_flag)) else $error("flag set in detect mode");
    char_cap_a: assert property (char_in |=> o_rx_buffer_full &&
        o_framing_error_flag == !$past(o_rx_level))
        else $error("character capture wrong");
endmodule // slc_status_ctrl_monitor

bind slc_status_ctrl slc_status_ctrl_monitor slc_status_ctrl_monitor_i (
    .i_mclk, .i_rst_b, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
    .i_loop_select, .i_receiver_source_select, .i_rx_pin, .i_char_done,
    .i_overrun_flag, .i_parity_error_flag, .i_tx_level, .i_send_break,
    .o_rx_level, .o_rx_buffer_full, .o_framing_error_flag, .o_noise_flag,
    .o_tx_break_active, .o_tx_pin, .o_tx_pin_oe, .o_error_irq);

// >>> bench/slc_status_ctrl_tb.sv
`timescale 1ns/100ps
module slc_status_ctrl_tb;
    reg i_mclk, i_rst_b, i_wr, i_rd, rx_tb, i_nine_bit_mode;
    reg [1:0] i_addr;
    reg [3:0] low_bits;
    reg [7:0] i_wr_data, i_rx_shift_data, ev;
    reg i_receiver_standby, i_loop_select, i_receiver_source_select;
    reg i_rx_shift_bit8, i_overrun_flag, i_parity_error_flag;
    reg i_tx_level, i_tx_bit_tick;
    integer failures, n_checks, cycles;
    wire line, i_rx_bit_tick, o_rx_level, o_rx_buffer_full, o_noise_flag;
    wire o_framing_error_flag, o_idle_flag, o_tx_ninth_bit, o_error_irq;
    wire o_tx_break_active, o_tx_pin, o_tx_pin_oe;
    wire [7:0] o_rd_data, o_rx_data;
    // Receive pin is the node's line, pulled low by the bench for noise and framing errors
    wire i_rx_pin = line & rx_tb;
    wire i_start_bit_valid = ev[0];
    wire i_idle_line = ev[1];
    wire i_char_done = ev[2];
    wire i_flag_clear = ev[3];
    wire i_send_break = ev[4];
    wire i_rx_sample_valid = ev[5];
    wire i_rx_bit_end = ev[6];
    slc_lin_node slc_lin_node_i (.i_mclk, .i_go(ev[7]),
        .i_low_bits(low_bits), .o_line(line), .o_tick(i_rx_bit_tick));
    slc_status_ctrl slc_status_ctrl_i (.i_mclk, .i_rst_b, .i_addr,
        .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_nine_bit_mode,
        .i_receiver_standby, .i_loop_select, .i_receiver_source_select,
        .i_rx_pin, .i_rx_bit_tick, .i_rx_sample_valid, .i_rx_bit_end,
        .i_start_bit_valid, .i_idle_line, .i_char_done, .i_rx_shift_data,
        .i_rx_shift_bit8, .i_flag_clear, .i_overrun_flag,
        .i_parity_error_flag, .i_tx_level, .i_tx_bit_tick, .i_send_break,
        .o_rx_level, .o_rx_data, .o_rx_buffer_full, .o_framing_error_flag,
        .o_noise_flag, .o_idle_flag, .o_tx_ninth_bit, .o_tx_break_active,
        .o_tx_pin, .o_tx_pin_oe, .o_error_irq);
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    // ----------------------------------------------------------------
    // Bus cycles, pulses and comparison
    // ----------------------------------------------------------------
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [1:0] a, input [7:0] d);
        begin
            @(posedge i_mclk);
            i_addr <= a;
            i_wr_data <= d;
            i_wr <= 1'b1;
            @(posedge i_mclk) i_wr <= 1'b0;
            @(negedge i_mclk);
        end
    endtask
    task rd(input [1:0] a, input [7:0] e);
        begin
            @(posedge i_mclk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_mclk) i_rd <= 1'b0;
            @(negedge i_mclk) chk(o_rd_data, e);
        end
    endtask
    task pulse(input [7:0] m);
        begin
            @(posedge i_mclk) ev <= m;
            @(posedge i_mclk) ev <= 8'h00;
            @(negedge i_mclk);
        end
    endtask
    // Low stretch from the node; bounded wait for the line to return
    task go(input [3:0] n);
        integer k;
        begin
            @(posedge i_mclk) low_bits <= n;
            pulse(8'h80);
            for (k = 0; k < 200 && line !== 1'b1; k = k + 1)
                @(negedge i_mclk);
        end
    endtask
    task report_and_stop;
        begin
            $display("Checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_regs;
        integer i;
        begin
            rd(2'h0, 8'h00);
            wr(2'h1, 8'hFF);
            chk({7'h00, o_tx_ninth_bit}, 8'h01);
            rd(2'h1, 8'h7F);
            wr(2'h0, 8'hEF);
            rd(2'h0, 8'h0E);
            chk({7'h00, o_tx_ninth_bit}, 8'h01);
            wr(2'h2, 8'hFF);
            rd(2'h2, 8'h00);
            @(posedge i_mclk) i_loop_select <= 1'b1;
            i_receiver_source_select <= 1'b1;
            i_tx_level <= 1'b0;
            for (i = 0; i < 2; i = i + 1) begin
                wr(2'h1, {2'h0, i[0], 5'h00});
                chk({7'h00, o_tx_pin_oe}, {7'h00, i[0]});
            end
            wr(2'h0, 8'h00);
        end
    endtask
    task t_edge;
        begin
            wr(2'h0, 8'h10);
            wr(2'h0, 8'h50);
            rd(2'h0, 8'h10);
            go(4'h1);
            rd(2'h0, 8'h50);
            wr(2'h0, 8'h40);
            rd(2'h0, 8'h00);
        end
    endtask
    task t_brk_rx;
        integer j;
        begin
            for (j = 0; j < 4; j = j + 1) begin
                @(posedge i_mclk) i_nine_bit_mode <= j[0];
                wr(2'h0, 8'h02);
                go(4'hA + {3'h0, j[0]} + {3'h0, j[1]});
                rd(2'h0, j[1] ? 8'hC2 : 8'h42);
                wr(2'h0, 8'h02);
                rd(2'h0, j[1] ? 8'hC2 : 8'h42);
                wr(2'h0, 8'hC2);
                rd(2'h0, 8'h02);
            end
        end
    endtask
    task t_brk_tx;
        integer i, k, n;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                @(posedge i_mclk) i_nine_bit_mode <= i[0];
                wr(2'h0, {5'h00, i[1], 2'h0});
                wr(2'h1, {3'h0, i[0], 4'h0});
                pulse(8'h10);
                n = 0;
                for (k = 0; k < 100 && o_tx_break_active === 1'b1; k = k + 1)
                begin
                    @(posedge i_mclk) i_tx_bit_tick <= (k % 4 == 3);
                    if (k % 4 == 3)
                        n = n + 1;
                    @(negedge i_mclk);
                end
                @(posedge i_mclk) i_tx_bit_tick <= 1'b0;
                chk(n[7:0], 8'h0A + {7'h00, i[0]} +
                    (i[1] ? 8'h03 : 8'h00));
            end
            wr(2'h0, 8'h00);
        end
    endtask
    task t_char;
        begin
            wr(2'h1, 8'h06);
            pulse(8'h01);
            rd(2'h0, 8'h01);
            @(posedge i_mclk) i_rx_shift_data <= 8'hA5;
            i_rx_shift_bit8 <= 1'b1;
            pulse(8'h20);
            @(posedge i_mclk) rx_tb <= 1'b0;
            pulse(8'h20);
            pulse(8'h40);
            @(posedge i_mclk) rx_tb <= 1'b1;
            pulse(8'h04);
            chk(o_rx_data, 8'hA5);
            chk({o_rx_buffer_full, o_noise_flag, o_framing_error_flag,
                o_error_irq, 4'h0}, 8'hD0);
            rd(2'h1, 8'h86);
            pulse(8'h08);
            chk({7'h00, o_rx_buffer_full}, 8'h00);
            @(posedge i_mclk) rx_tb <= 1'b0;
            pulse(8'h04);
            chk({o_rx_buffer_full, o_framing_error_flag, o_error_irq, 5'h00},
                8'hE0);
            pulse(8'h08);
            wr(2'h0, 8'h02);
            pulse(8'h04);
            chk({6'h00, o_rx_buffer_full, o_framing_error_flag}, 8'h00);
            @(posedge i_mclk) rx_tb <= 1'b1;
            wr(2'h0, 8'h40);
            @(posedge i_mclk) i_overrun_flag <= 1'b1;
            i_parity_error_flag <= 1'b1;
            wr(2'h1, 8'h08);
            chk({7'h00, o_error_irq}, 8'h01);
            wr(2'h1, 8'h01);
            chk({7'h00, o_error_irq}, 8'h01);
            wr(2'h1, 8'h00);
            chk({7'h00, o_error_irq}, 8'h00);
        end
    endtask
    task t_idle;
        integer i;
        begin
            @(posedge i_mclk) i_receiver_standby <= 1'b1;
            for (i = 0; i < 2; i = i + 1) begin
                wr(2'h0, {4'h0, i[0], 3'h0});
                pulse(8'h01);
                pulse(8'h02);
                chk({7'h00, o_idle_flag}, {7'h00, i[0]});
                rd(2'h0, {4'h0, i[0], 3'h0});
                pulse(8'h08);
            end
        end
    endtask
    // A hung wait is cut short and counted as a failure
    always @(posedge i_mclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    initial begin
        {i_rst_b, i_wr, i_rd, i_nine_bit_mode, i_receiver_standby} = 5'h00;
        {i_loop_select, i_receiver_source_select, i_rx_shift_bit8} = 3'h0;
        {i_overrun_flag, i_parity_error_flag, i_tx_bit_tick} = 3'h0;
        i_addr = 2'h0;
        low_bits = 4'h0;
        i_wr_data = 8'h00;
        i_rx_shift_data = 8'h00;
        ev = 8'h00;
        rx_tb = 1'b1;
        i_tx_level = 1'b1;
        failures = 0;
        n_checks = 0;
        cycles = 0;
        repeat (2) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        t_regs;
        t_edge;
        t_brk_rx;
        t_brk_tx;
        t_char;
        t_idle;
        report_and_stop;
    end
endmodule // slc_status_ctrl_tb

// >>> hw/slc_bit_counter.v
`timescale 1ns/100ps
`include "slc_map.vh"

// Counts bit-time ticks up to a limit and holds there until cleared
module slc_bit_counter (
    input wire i_mclk,
    input wire i_rst_b,
    input wire i_clear,
    input wire i_tick,
    input wire [3:0] i_limit,
    output wire o_done
);

reg [3:0] count;

// ----------------------------------------------------------------
// Saturating counter
// ----------------------------------------------------------------
// Saturates so a long low line cannot wrap and fire twice
always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        count <= `SLC_CNT_ZERO;
    end else if (i_clear) begin
        count <= `SLC_CNT_ZERO;
    end else if (i_tick && (count != i_limit)) begin
        count <= count + `SLC_CNT_ONE;
    end
end

assign o_done = (count == i_limit);

endmodule // slc_bit_counter

// >>> hw/slc_map.vh
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

// ----------------------------------------------------------------
// Register addresses on the plain port
// ----------------------------------------------------------------
`define SLC_ADDR_W 2
`define SLC_ADDR_STATUS 2'h0
`define SLC_ADDR_CTRL 2'h1

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SLC_S_BRK_IF 7
`define SLC_S_EDGE_IF 6
`define SLC_S_RX_POLARITY_INVERT 4
`define SLC_S_STANDBY_IDLE_FLAG_SELECT 3
`define SLC_S_LONG_BREAK_TX_SELECT 2
`define SLC_S_LONG_BREAK_DETECT_ENABLE 1
`define SLC_S_RAF 0

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SLC_C_R8 7
`define SLC_C_T8 6
`define SLC_C_SINGLE_WIRE_PIN_DIRECTION 5
`define SLC_C_TX_POLARITY_INVERT 4
`define SLC_C_OVERRUN_IRQ_ENABLE 3
`define SLC_C_NOISE_IRQ_ENABLE 2
`define SLC_C_FRAMING_IRQ_ENABLE 1
`define SLC_C_PARITY_IRQ_ENABLE 0

// ----------------------------------------------------------------
// Reset values and lengths in bit times
// ----------------------------------------------------------------
`define SLC_RST_BYTE 8'h00
`define SLC_ZERO_BYTE 8'h00
`define SLC_CNT_ZERO 4'h0
`define SLC_CNT_ONE 4'h1
`define SLC_SMP_ZERO 3'h0
`define SLC_SMP_ONE 3'h1
`define SLC_TXBRK_SHORT 4'hA
`define SLC_TXBRK_LONG 4'hD
`define SLC_RXBRK_SHORT 4'hA
`define SLC_RXBRK_LONG 4'hB

`endif

// >>> hw/slc_status_ctrl.v
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "slc_map.vh"

module slc_status_ctrl (
    input wire i_mclk,
    input wire i_rst_b,
    input wire [1:0] i_addr,
    input wire [7:0] i_wr_data,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rd_data,
    input wire i_nine_bit_mode,
    input wire i_receiver_standby,
    input wire i_loop_select,
    input wire i_receiver_source_select,
    input wire i_rx_pin,
    input wire i_rx_bit_tick,
    input wire i_rx_sample_valid,
    input wire i_rx_bit_end,
    input wire i_start_bit_valid,
    input wire i_idle_line,
    input wire i_char_done,
    input wire [7:0] i_rx_shift_data,
    input wire i_rx_shift_bit8,
    input wire i_flag_clear,
    input wire i_overrun_flag,
    input wire i_parity_error_flag,
    input wire i_tx_level,
    input wire i_tx_bit_tick,
    input wire i_send_break,
    output wire o_rx_level,
    output reg [7:0] o_rx_data,
    output reg o_rx_buffer_full,
    output reg o_framing_error_flag,
    output reg o_noise_flag,
    output reg o_idle_flag,
    output wire o_tx_ninth_bit,
    output wire o_tx_break_active,
    output wire o_tx_pin,
    output wire o_tx_pin_oe,
    output wire o_error_irq
);

// ----------------------------------------------------------------
// Break length decode, shared by transmit and receive counters
// ----------------------------------------------------------------
function [3:0] slc_len;
    input nine;
    input long_sel;
    input [3:0] short_len;
    input [3:0] long_len;
    begin
        slc_len = (long_sel ? long_len : short_len) +
                  (nine ? `SLC_CNT_ONE : `SLC_CNT_ZERO);
    end
endfunction

reg break_detect_irq_flag;
reg rx_edge_irq_flag;
reg rx_polarity_invert;
reg standby_idle_flag_select;
reg long_break_tx_select;
reg long_break_detect_enable;
reg receiver_active_flag;
reg rx_ninth_bit;
reg tx_ninth_bit;
reg single_wire_pin_direction;
reg tx_polarity_invert;
reg overrun_irq_enable;
reg noise_irq_enable;
reg framing_irq_enable;
reg parity_irq_enable;
reg rx_pin_q;
reg rx_brk_done_q;
reg tx_break_on;
reg [2:0] samp_cnt;
reg [2:0] ones_cnt;
reg frame_noise;
reg [7:0] next_rd_data;

wire wr_status, wr_ctrl, rx_level, edge_hit;
wire brk_done, brk_hit, tx_brk_done;
wire bit_noisy, accept_char, single_wire;

assign wr_status = i_wr && (i_addr == `SLC_ADDR_STATUS);
assign wr_ctrl = i_wr && (i_addr == `SLC_ADDR_CTRL);

// ----------------------------------------------------------------
// Receive line conditioning
// ----------------------------------------------------------------
// One XOR ahead of everything so break, idle, start and data agree
assign rx_level = i_rx_pin ^ rx_polarity_invert;
assign o_rx_level = rx_level;
// Raw pin edge by invert bit; toggling that bit alone is no edge
assign edge_hit = (rx_pin_q != i_rx_pin) &&
                  (i_rx_pin == rx_polarity_invert);

always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        rx_pin_q <= 1'b1;
        rx_brk_done_q <= 1'b0;
    end else begin
        rx_pin_q <= i_rx_pin;
        rx_brk_done_q <= brk_done;
    end
end

// ----------------------------------------------------------------
// Break detection: consecutive low bit times
// ----------------------------------------------------------------
slc_bit_counter u_rx_break (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_clear(rx_level),
    .i_tick(i_rx_bit_tick),
    .i_limit(slc_len(i_nine_bit_mode, long_break_detect_enable,
                     `SLC_RXBRK_SHORT, `SLC_RXBRK_LONG)),
    .o_done(brk_done)
);

// Flag only on the first cycle the threshold is met
assign brk_hit = brk_done && !rx_brk_done_q && long_break_detect_enable;

// ----------------------------------------------------------------
// Break transmission
// ----------------------------------------------------------------
slc_bit_counter u_tx_break (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_clear(!tx_break_on),
    .i_tick(i_tx_bit_tick),
    .i_limit(slc_len(i_nine_bit_mode, long_break_tx_select,
                     `SLC_TXBRK_SHORT, `SLC_TXBRK_LONG)),
    .o_done(tx_brk_done)
);

// A request during a running break is absorbed into it
always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        tx_break_on <= 1'b0;
    end else if (i_send_break) begin
        tx_break_on <= 1'b1;
    end else if (tx_brk_done) begin
        tx_break_on <= 1'b0;
    end
end

assign o_tx_break_active = tx_break_on;

// ----------------------------------------------------------------
// Transmit pin and direction
// ----------------------------------------------------------------
assign o_tx_pin = (tx_break_on ? 1'b0 : i_tx_level) ^
                  tx_polarity_invert;
assign single_wire = i_loop_select && i_receiver_source_select;
assign o_tx_pin_oe = !single_wire || single_wire_pin_direction;
assign o_tx_ninth_bit = tx_ninth_bit;

// ----------------------------------------------------------------
// Sample agreement check per bit time
// ----------------------------------------------------------------
// Counting ones against samples covers both the seven-sample start
// bit and the three-sample data bits without knowing which it is
assign bit_noisy = (ones_cnt != `SLC_SMP_ZERO) &&
                   (ones_cnt != samp_cnt);

always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        samp_cnt <= `SLC_SMP_ZERO;
        ones_cnt <= `SLC_SMP_ZERO;
        frame_noise <= 1'b0;
    end else begin
        if (i_rx_bit_end) begin
            samp_cnt <= `SLC_SMP_ZERO;
            ones_cnt <= `SLC_SMP_ZERO;
        end else if (i_rx_sample_valid) begin
            samp_cnt <= samp_cnt + `SLC_SMP_ONE;
            ones_cnt <= ones_cnt +
                        (rx_level ? `SLC_SMP_ONE : `SLC_SMP_ZERO);
        end
        if (i_start_bit_valid) begin
            frame_noise <= 1'b0;
        end else if (i_rx_bit_end && bit_noisy) begin
            frame_noise <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Receive buffer and first-status flags
// ----------------------------------------------------------------
// A full buffer keeps old data and ninth bit; overrun is outside
assign accept_char = i_char_done && !o_rx_buffer_full &&
                     !long_break_detect_enable;

always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        o_rx_data <= `SLC_ZERO_BYTE;
        rx_ninth_bit <= 1'b0;
        o_rx_buffer_full <= 1'b0;
        o_framing_error_flag <= 1'b0;
        o_noise_flag <= 1'b0;
        o_idle_flag <= 1'b0;
    end else begin
        if (accept_char) begin
            o_rx_data <= i_rx_shift_data;
            rx_ninth_bit <= i_rx_shift_bit8;
        end
        // Set beats a clear arriving in the same cycle
        if (accept_char) begin
            o_rx_buffer_full <= 1'b1;
            o_framing_error_flag <= !rx_level;
            o_noise_flag <= frame_noise;
        end else if (i_flag_clear) begin
            o_rx_buffer_full <= 1'b0;
            o_framing_error_flag <= 1'b0;
            o_noise_flag <= 1'b0;
        end
        if (i_idle_line &&
            (!i_receiver_standby || standby_idle_flag_select)) begin
            o_idle_flag <= 1'b1;
        end else if (i_flag_clear) begin
            o_idle_flag <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Receiver active flag
// ----------------------------------------------------------------
always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        receiver_active_flag <= 1'b0;
    end else if (i_start_bit_valid) begin
        receiver_active_flag <= 1'b1;
    end else if (i_idle_line) begin
        receiver_active_flag <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Status register writes and event flags
// ----------------------------------------------------------------
always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        break_detect_irq_flag <= 1'b0;
        rx_edge_irq_flag <= 1'b0;
        rx_polarity_invert <= 1'b0;
        standby_idle_flag_select <= 1'b0;
        long_break_tx_select <= 1'b0;
        long_break_detect_enable <= 1'b0;
    end else begin
        if (brk_hit) begin
            break_detect_irq_flag <= 1'b1;
        end else if (wr_status && i_wr_data[`SLC_S_BRK_IF]) begin
            break_detect_irq_flag <= 1'b0;
        end
        if (edge_hit) begin
            rx_edge_irq_flag <= 1'b1;
        end else if (wr_status && i_wr_data[`SLC_S_EDGE_IF]) begin
            rx_edge_irq_flag <= 1'b0;
        end
        if (wr_status) begin
            rx_polarity_invert <= i_wr_data[`SLC_S_RX_POLARITY_INVERT];
            standby_idle_flag_select <= i_wr_data[`SLC_S_STANDBY_IDLE_FLAG_SELECT];
            long_break_tx_select <= i_wr_data[`SLC_S_LONG_BREAK_TX_SELECT];
            long_break_detect_enable <= i_wr_data[`SLC_S_LONG_BREAK_DETECT_ENABLE];
        end
    end
end

// ----------------------------------------------------------------
// Control register writes
// ----------------------------------------------------------------
// Ninth receive bit is read-only here; writes to it are dropped
always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        tx_ninth_bit <= 1'b0;
        single_wire_pin_direction <= 1'b0;
        tx_polarity_invert <= 1'b0;
        overrun_irq_enable <= 1'b0;
        noise_irq_enable <= 1'b0;
        framing_irq_enable <= 1'b0;
        parity_irq_enable <= 1'b0;
    end else if (wr_ctrl) begin
        tx_ninth_bit <= i_wr_data[`SLC_C_T8];
        single_wire_pin_direction <= i_wr_data[`SLC_C_SINGLE_WIRE_PIN_DIRECTION];
        tx_polarity_invert <= i_wr_data[`SLC_C_TX_POLARITY_INVERT];
        overrun_irq_enable <= i_wr_data[`SLC_C_OVERRUN_IRQ_ENABLE];
        noise_irq_enable <= i_wr_data[`SLC_C_NOISE_IRQ_ENABLE];
        framing_irq_enable <= i_wr_data[`SLC_C_FRAMING_IRQ_ENABLE];
        parity_irq_enable <= i_wr_data[`SLC_C_PARITY_IRQ_ENABLE];
    end
end

// ----------------------------------------------------------------
// Error interrupt request
// ----------------------------------------------------------------
// Level request; it drops as soon as no source has both its flag and its enable set
assign o_error_irq =
    (i_overrun_flag && overrun_irq_enable) ||
    (o_noise_flag && noise_irq_enable) ||
    (o_framing_error_flag && framing_irq_enable) ||
    (i_parity_error_flag && parity_irq_enable);

// ----------------------------------------------------------------
// Read path
// ----------------------------------------------------------------
// Unmapped addresses read as zero; unused bit positions read zero
always @* begin
    next_rd_data = `SLC_ZERO_BYTE;
    case (i_addr)
        `SLC_ADDR_STATUS: begin
            next_rd_data[`SLC_S_BRK_IF] = break_detect_irq_flag;
            next_rd_data[`SLC_S_EDGE_IF] = rx_edge_irq_flag;
            next_rd_data[`SLC_S_RX_POLARITY_INVERT] = rx_polarity_invert;
            next_rd_data[`SLC_S_STANDBY_IDLE_FLAG_SELECT] = standby_idle_flag_select;
            next_rd_data[`SLC_S_LONG_BREAK_TX_SELECT] = long_break_tx_select;
            next_rd_data[`SLC_S_LONG_BREAK_DETECT_ENABLE] = long_break_detect_enable;
            next_rd_data[`SLC_S_RAF] = receiver_active_flag;
        end
        `SLC_ADDR_CTRL: begin
            next_rd_data[`SLC_C_R8] = rx_ninth_bit;
            next_rd_data[`SLC_C_T8] = tx_ninth_bit;
            next_rd_data[`SLC_C_SINGLE_WIRE_PIN_DIRECTION] = single_wire_pin_direction;
            next_rd_data[`SLC_C_TX_POLARITY_INVERT] = tx_polarity_invert;
            next_rd_data[`SLC_C_OVERRUN_IRQ_ENABLE] = overrun_irq_enable;
            next_rd_data[`SLC_C_NOISE_IRQ_ENABLE] = noise_irq_enable;
            next_rd_data[`SLC_C_FRAMING_IRQ_ENABLE] = framing_irq_enable;
            next_rd_data[`SLC_C_PARITY_IRQ_ENABLE] = parity_irq_enable;
        end
        default: next_rd_data = `SLC_ZERO_BYTE;
    endcase
end

// Read data stand only in the cycle after the strobe
always @(posedge i_mclk) begin
    if (!i_rst_b) begin
        o_rd_data <= `SLC_RST_BYTE;
    end else if (i_rd) begin
        o_rd_data <= next_rd_data;
    end else begin
        o_rd_data <= `SLC_RST_BYTE;
    end
end

endmodule // slc_status_ctrl
